// >>> emm_pkg.sv
/*
 package for the emulator memory mode mapper: address ranges, vectors,
 jumper codes, mode encoding and the bus sample carrier.
 assumes a 16-bit logical address from the processor.
*/
`default_nettype none
package emm_pkg;
   // ------------------------------------------------------------
   // address fields
   // ------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int HALF_BIT = 15;
   localparam int BLK_HI = 15;
   localparam int BLK_LO = 13;
   localparam int PAGE_HI = 12;
   localparam int PAGE_LO = 8;
   localparam logic [4:0] LAST_PAGE = 5'h1f;
   // 16 KB range selectors, address bits 15:14, and 8 KB block codes, address bits 15:13
   localparam logic [1:0] RANGE_ONE_ACC = 2'h0;
   localparam logic [2:0] BLK_ONE_ACC = 3'h0;
   localparam logic [2:0] BLK_TWO_ACC = 3'h1;
   localparam logic [1:0] RANGE_USER_REQ = 2'h1;
   // ------------------------------------------------------------
   // vectors that return the board to monitor mode
   // ------------------------------------------------------------
   localparam logic [15:0] VEC_RESET = 16'h0000;
   localparam logic [15:0] VEC_SERVICE = 16'h0020;
   localparam logic [15:0] VEC_BREAK = 16'h0028;
   localparam logic [15:0] VEC_NMI = 16'h0066;
   // ------------------------------------------------------------
   // pending user access counts and jumper code
   // ------------------------------------------------------------
   localparam logic [1:0] PEND_NONE = 2'h0;
   localparam logic [1:0] PEND_ONE = 2'h1;
   localparam logic [1:0] PEND_TWO = 2'h2;
   localparam logic [2:0] RAM_OFF_CODE = 3'h5;
   localparam logic [1:0] SYNC_INIT = 2'h0;
   typedef enum logic [1:0] {
      EMM_MONITOR = 2'b01,
      EMM_USER    = 2'b10
   } emm_mode_t;
   // bus sample, all flags active high
   typedef struct packed {
      logic [15:0] addr;
      logic        memory_request_strobe;
      logic        fetch;
      logic        wr;
   } emm_bus_t;
   // board buttons and jumpers, active high (pressed / inserted)
   typedef struct packed {
      logic [2:0] ram_window_jumpers;
      logic       reset_out_jumper;
      logic       interrupt_out_jumper;
      logic       reset_button;
      logic       nmi_button;
   } emm_board_t;
endpackage
`default_nettype wire

// >>> emm_mapper.sv
/*
 memory mode mapper of the emulator board: tracks monitor and user mode,
 selects the on-board rom and ram and gates the memory request strobe
 toward the target board.
 assumes the processor bus and the board buttons/jumpers are asynchronous
 to clk_sys_in and are sampled through two flip-flops each; a bus cycle
 lasts several clk_sys_in periods.
*/
`timescale 1ns/1ps
`default_nettype none
module emm_mapper (
   // clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       rst_b_in,
   // processor bus
   input  wire logic [15:0] addr_in,
   input  wire logic       memory_request_strobe_b_in,
   input  wire logic       opcode_fetch_cycle_b_in,
   input  wire logic       write_strobe_b_in,
   // board buttons and jumpers, low when pressed or inserted
   input  wire logic [2:0] ram_window_jumpers_b_in,
   input  wire logic       reset_out_jumper_b_in,
   input  wire logic       interrupt_out_jumper_b_in,
   input  wire logic       reset_button_b_in,
   input  wire logic       nmi_button_b_in,
   // memory selects
   output logic            rom_select_b_out,
   output logic            ram_select_b_out,
   output logic            target_memory_request_b_out,
   // target board control
   output logic            target_reset_b_out,
   output logic            target_nmi_b_out,
   // status
   output logic            user_mode_out
);

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   emm_pkg::emm_bus_t   bus_raw;
   emm_pkg::emm_bus_t   bus_s1_r;
   emm_pkg::emm_bus_t   bus_s2_r;
   emm_pkg::emm_bus_t   bus_s3_r;
   emm_pkg::emm_board_t brd_raw;
   emm_pkg::emm_board_t brd_s1_r;
   emm_pkg::emm_board_t brd_s2_r;

   assign bus_raw = '{addr:  addr_in,
                      memory_request_strobe:  ~memory_request_strobe_b_in,
                      fetch: ~opcode_fetch_cycle_b_in,
                      wr:    ~write_strobe_b_in};
   assign brd_raw = '{ram_window_jumpers:   ~ram_window_jumpers_b_in,
                      reset_out_jumper:     ~reset_out_jumper_b_in,
                      interrupt_out_jumper: ~interrupt_out_jumper_b_in,
                      reset_button:         ~reset_button_b_in,
                      nmi_button:           ~nmi_button_b_in};

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         bus_s1_r <= '0;
         bus_s2_r <= '0;
         bus_s3_r <= '0;
         brd_s1_r <= '0;
         brd_s2_r <= '0;
      end else begin
         bus_s1_r <= bus_raw;
         bus_s2_r <= bus_s1_r;
         bus_s3_r <= bus_s2_r;
         brd_s1_r <= brd_raw;
         brd_s2_r <= brd_s1_r;
      end
   end

   // ------------------------------------------------------------
   // cycle framing
   // ------------------------------------------------------------
   // write strobe comes late in the cycle, so mode writes act at the end
   wire cyc_start = bus_s2_r.memory_request_strobe & ~bus_s3_r.memory_request_strobe;
   wire cyc_end   = ~bus_s2_r.memory_request_strobe & bus_s3_r.memory_request_strobe;
   wire active    = bus_s2_r.memory_request_strobe;

   emm_pkg::emm_mode_t mode_r;
   emm_pkg::emm_mode_t mode_nxt;
   logic [1:0]         pend_r;
   logic [1:0]         pend_nxt;
   logic               grant_r;
   logic               wr_seen_r;
   logic               qual_write;

   function automatic logic is_vector(input logic [15:0] a);
      is_vector = (a == emm_pkg::VEC_RESET) || (a == emm_pkg::VEC_SERVICE) ||
                  (a == emm_pkg::VEC_BREAK) || (a == emm_pkg::VEC_NMI);
   endfunction

   wire vec_hit = cyc_start & bus_s2_r.fetch & is_vector(bus_s2_r.addr);
   // a granted access is a data cycle taken while accesses are pending
   wire grant_now = (pend_r != emm_pkg::PEND_NONE) & ~bus_s2_r.fetch;
   wire grant     = cyc_start ? grant_now : grant_r;

   // ------------------------------------------------------------
   // mode and pending count
   // ------------------------------------------------------------
   localparam int BLK_HI_C = emm_pkg::BLK_HI;
   localparam int BLK_LO_C = emm_pkg::BLK_LO;
   wire [15:0] end_addr   = bus_s3_r.addr;
   wire        end_write  = cyc_end & wr_seen_r & (mode_r == emm_pkg::EMM_MONITOR) & ~grant_r;
   wire        wr_one     = end_write & (end_addr[BLK_HI_C:BLK_LO_C] == emm_pkg::BLK_ONE_ACC);
   wire        wr_two     = end_write & (end_addr[BLK_HI_C:BLK_LO_C] == emm_pkg::BLK_TWO_ACC);
   wire        wr_user    = end_write & (end_addr[15:14] == emm_pkg::RANGE_USER_REQ);

   assign qual_write = wr_one | wr_two;

   always_comb begin
      mode_nxt = mode_r;
      if (mode_r == emm_pkg::EMM_USER && vec_hit) begin
         mode_nxt = emm_pkg::EMM_MONITOR;
      end else if (wr_user) begin
         mode_nxt = emm_pkg::EMM_USER;
      end
   end

   always_comb begin
      pend_nxt = pend_r;
      if (wr_one) begin
         pend_nxt = emm_pkg::PEND_ONE;
      end else if (wr_two) begin
         pend_nxt = emm_pkg::PEND_TWO;
      end else if (cyc_end && grant_r) begin
         pend_nxt = pend_r - 2'h1;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         mode_r    <= emm_pkg::EMM_MONITOR;
         pend_r    <= emm_pkg::PEND_NONE;
         grant_r   <= 1'b0;
         wr_seen_r <= 1'b0;
      end else begin
         mode_r    <= mode_nxt;
         pend_r    <= pend_nxt;
         if (cyc_start) begin
            grant_r <= grant_now;
         end
         wr_seen_r <= active & (wr_seen_r | bus_s2_r.wr);
      end
   end

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   wire [15:0] a       = bus_s2_r.addr;
   wire        user_map = (mode_nxt == emm_pkg::EMM_USER) | grant;
   // an inserted jumper reads as 1; the window block is the inverted code
   wire [2:0]  jcode   = brd_s2_r.ram_window_jumpers;
   wire        ram_en  = (jcode != emm_pkg::RAM_OFF_CODE);
   wire        win_hit = ram_en & (a[BLK_HI_C:BLK_LO_C] == ~jcode);
   // top page kept for the monitor's own stack and data
   wire        top_pg  = (a[emm_pkg::PAGE_HI:emm_pkg::PAGE_LO] == emm_pkg::LAST_PAGE);
   wire        u_ram   = win_hit & ~top_pg;
   wire        m_rom   = ~a[emm_pkg::HALF_BIT];
   wire        m_ram   = a[emm_pkg::HALF_BIT];

   wire rom_nxt = active & ~user_map & m_rom;
   wire ram_nxt = active & (user_map ? u_ram : m_ram);
   wire tgt_nxt = active & user_map & ~u_ram;
   wire rst_nxt = brd_s2_r.reset_out_jumper & brd_s2_r.reset_button;
   wire nmi_nxt = brd_s2_r.interrupt_out_jumper & brd_s2_r.nmi_button;

   // ------------------------------------------------------------
   // registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         rom_select_b_out            <= 1'b1;
         ram_select_b_out            <= 1'b1;
         target_memory_request_b_out <= 1'b1;
         target_reset_b_out          <= 1'b1;
         target_nmi_b_out            <= 1'b1;
         user_mode_out               <= 1'b0;
      end else begin
         rom_select_b_out            <= ~rom_nxt;
         ram_select_b_out            <= ~ram_nxt;
         target_memory_request_b_out <= ~tgt_nxt;
         target_reset_b_out          <= ~rst_nxt;
         target_nmi_b_out            <= ~nmi_nxt;
         user_mode_out               <= (mode_nxt == emm_pkg::EMM_USER);
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_b_in);

   a_reset_monitor: assert property ($rose(rst_b_in) |-> mode_r == emm_pkg::EMM_MONITOR)
      else $error("mode not monitor after reset");

   a_vector_exit: assert property (
      (mode_r == emm_pkg::EMM_USER && vec_hit) |=>
      (mode_r == emm_pkg::EMM_MONITOR) && !user_mode_out)
      else $error("vector fetch did not leave user mode");

   a_monitor_rom: assert property (
      (active && !user_map && !a[15]) |=> !rom_select_b_out && ram_select_b_out)
      else $error("monitor rom select wrong");

   a_monitor_ram: assert property (
      (active && !user_map && a[15]) |=> !ram_select_b_out && rom_select_b_out)
      else $error("monitor ram select wrong");

   a_one_access: assert property (wr_one |=> pend_r == emm_pkg::PEND_ONE)
      else $error("one pending access not loaded");

   a_two_access: assert property (wr_two |=> pend_r == emm_pkg::PEND_TWO)
      else $error("two pending accesses not loaded");

   a_target_block: assert property (
      (active && mode_nxt == emm_pkg::EMM_MONITOR && !grant) |=> target_memory_request_b_out)
      else $error("target strobe leaked in monitor mode");

   a_user_entry: assert property (wr_user && !vec_hit |=> user_mode_out ##1 user_mode_out)
      else $error("user request not taken");

   a_user_no_rom: assert property (user_map |=> rom_select_b_out)
      else $error("rom selected under user mapping");

   a_ram_off: assert property (
      (jcode == emm_pkg::RAM_OFF_CODE && user_map) |=> ram_select_b_out)
      else $error("ram selected while jumpered off");

   a_ram_private: assert property ((user_map && top_pg) |=> ram_select_b_out)
      else $error("private ram page exposed");

   a_user_target: assert property (
      (active && user_map) |=> (target_memory_request_b_out != ram_select_b_out))
      else $error("target strobe and ram select overlap");

   a_button_out: assert property (
      (brd_s2_r.reset_out_jumper && brd_s2_r.reset_button) |=> !target_reset_b_out)
      else $error("reset button not passed to target");

   a_count_down: assert property (
      (cyc_end && grant_r && !qual_write) |=> pend_r == $past(pend_r) - 2'h1)
      else $error("pending count not decremented");

endmodule // emm_mapper
`default_nettype wire

// >>> emm_cpu_model.sv
/*
 processor bus model for the mode mapper bench: one memory cycle per request.
 assumes the bench raises req_in.memory_request_strobe and holds it until done_out.
*/
`timescale 1ns/1ps
`default_nettype none
module emm_cpu_model (
   // clock and reset
   input  wire logic              clk_sys_in,
   input  wire logic              rst_b_in,
   // request, flags active high
   input  wire emm_pkg::emm_bus_t req_in,
   // bus pins
   output logic [15:0]            addr_out,
   output logic                   memory_request_strobe_b_out,
   output logic                   fetch_b_out,
   output logic                   wr_b_out,
   // phase marks
   output logic                   mid_out,
   output logic                   done_out
);
   // ------------------------------------------------------------
   // cycle sequencer
   // ------------------------------------------------------------
   logic [3:0] cnt_r;
   logic       go_r;
   // six clocks low and six high, so the two-flop sync sees both phases
   always_ff @(posedge clk_sys_in) begin
      go_r <= req_in.memory_request_strobe;
      mid_out <= 1'b0;
      done_out <= 1'b0;
      if (!rst_b_in) begin
         cnt_r <= 4'h0;
         memory_request_strobe_b_out <= 1'b1;
         fetch_b_out <= 1'b1;
         wr_b_out <= 1'b1;
         addr_out <= 16'h0000;
      end else if (cnt_r == 4'h0) begin
         // idle address never holds the last value
         addr_out <= addr_out + 16'h3b1d;
         if (req_in.memory_request_strobe && !go_r) begin
            cnt_r <= 4'h1;
            addr_out <= req_in.addr;
            memory_request_strobe_b_out <= 1'b0;
            fetch_b_out <= !req_in.fetch;
            wr_b_out <= !req_in.wr;
         end
      end else begin
         cnt_r <= cnt_r + 4'h1;
         mid_out <= (cnt_r == 4'h5);
         if (cnt_r == 4'h6) begin
            memory_request_strobe_b_out <= 1'b1;
            fetch_b_out <= 1'b1;
            wr_b_out <= 1'b1;
            addr_out <= ~addr_out;
         end
         if (cnt_r == 4'hc) begin
            done_out <= 1'b1;
            cnt_r <= 4'h0;
         end
      end
   end
endmodule // emm_cpu_model
`default_nettype wire

// >>> emm_mapper_bench.sv
/*
 self-checking bench of the mode mapper: random and corner bus cycles.
 assumes emm_pkg and emm_cpu_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module emm_mapper_bench;
   logic              clk_sys_in;
   logic              rst_b;
   logic [2:0]        jb;
   logic [3:0]        btn;
   emm_pkg::emm_bus_t bus;
   logic [15:0]       addr;
   logic              memory_request_strobe_b, fetch_b, wr_b, mid, done;
   logic              rom_b, ram_b, tgt_b, trst_b, tnmi_b, user;
   logic              usr_m;
   logic [1:0]        pend;
   logic [31:0]       r;
   logic [15:0]       vecs [4];
   int                err_count;
   int                compares;
   int                seed;
   initial begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end
   emm_cpu_model CPU (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b), .req_in(bus),
      .addr_out(addr), .memory_request_strobe_b_out(memory_request_strobe_b), .fetch_b_out(fetch_b), .wr_b_out(wr_b),
      .mid_out(mid), .done_out(done));
   emm_mapper DUT (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b), .addr_in(addr),
      .memory_request_strobe_b_in(memory_request_strobe_b), .opcode_fetch_cycle_b_in(fetch_b),
      .write_strobe_b_in(wr_b), .ram_window_jumpers_b_in(jb),
      .reset_out_jumper_b_in(btn[3]), .interrupt_out_jumper_b_in(btn[2]),
      .reset_button_b_in(btn[1]), .nmi_button_b_in(btn[0]), .rom_select_b_out(rom_b),
      .ram_select_b_out(ram_b), .target_memory_request_b_out(tgt_b),
      .target_reset_b_out(trst_b), .target_nmi_b_out(tnmi_b), .user_mode_out(user));
   // ------------------------------------------------------------
   // expectations and checks
   // ------------------------------------------------------------
   // {rom, ram, target strobe}, all active low
   function automatic logic [2:0] exp_sel(input logic [15:0] a, input logic g);
      logic hit;
      hit = a[15:13] == jb && jb != ~emm_pkg::RAM_OFF_CODE && a[12:8] != 5'h1f;
      if (g)
         return {1'b1, !hit, hit};
      return {a[15], !a[15], 1'b1};
   endfunction
   task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic wait_ev(input logic on_done);
      int n;
      n = 0;
      do begin
         @(negedge clk_sys_in);
         n++;
      end while (!(on_done ? done : mid) && n < 40);
      if (!(on_done ? done : mid)) begin
         err_count++;
         report_and_stop();
      end
   endtask
   task automatic acc(input logic [15:0] a, input logic f, input logic w);
      logic g;
      if (f && usr_m && (a == vecs[0] || a == vecs[1] || a == vecs[2] || a == vecs[3]))
         usr_m = 1'b0;
      g = usr_m || (pend != emm_pkg::PEND_NONE && !f);
      @(posedge clk_sys_in) bus <= '{addr: a, memory_request_strobe: 1'b1, fetch: f, wr: w};
      wait_ev(1'b0);
      chk("selects", {1'b0, rom_b, ram_b, tgt_b},
          {1'b0, exp_sel(a, g)});
      wait_ev(1'b1);
      @(posedge clk_sys_in) bus.memory_request_strobe <= 1'b0;
      if (!usr_m && !f && pend != emm_pkg::PEND_NONE)
         pend = pend - 2'h1;
      else if (!usr_m && w && a[15:13] == emm_pkg::BLK_ONE_ACC)
         pend = emm_pkg::PEND_ONE;
      else if (!usr_m && w && a[15:13] == emm_pkg::BLK_TWO_ACC)
         pend = emm_pkg::PEND_TWO;
      else if (!usr_m && w && a[15:14] == emm_pkg::RANGE_USER_REQ)
         usr_m = 1'b1;
      chk("mode", {3'h0, user}, {3'h0, usr_m});
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rst_b = 1'b0;
      jb = 3'h7;
      btn = 4'hf;
      bus = '0;
      usr_m = 1'b0;
      pend = 2'h0;
      err_count = 0;
      compares = 0;
      vecs = '{emm_pkg::VEC_RESET, emm_pkg::VEC_SERVICE, emm_pkg::VEC_BREAK, emm_pkg::VEC_NMI};
      seed = $urandom(63792);
      // three reset edges; sync stages clear on the first one
      repeat (2) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk("reset", {rom_b, ram_b, tgt_b, user}, 4'he);
      @(posedge clk_sys_in) rst_b <= 1'b1;
      repeat (12) begin
         r = $urandom;
         acc(r[15:0], r[16], 1'b0);
      end
      acc(emm_pkg::VEC_BREAK, 1'b1, 1'b0);
      acc(16'h1ffe, 1'b0, 1'b1);
      acc(16'h0abc, 1'b1, 1'b0);
      acc(16'hf123, 1'b0, 1'b0);
      acc(16'hf123, 1'b0, 1'b0);
      acc(16'h2000, 1'b0, 1'b1);
      repeat (3) acc(16'hbf00, 1'b0, 1'b0);
      acc(16'h7fff, 1'b0, 1'b1);
      for (int c = 0; c < 8; c++) begin
         @(posedge clk_sys_in) jb <= c[2:0];
         r = $urandom;
         acc({c[2:0], 13'h0000}, 1'b0, 1'b0);
         acc({c[2:0], 5'h1f, r[7:0]}, 1'b0, 1'b1);
         acc({c[2:0], 5'h1e, r[7:0]}, 1'b1, 1'b0);
         acc({c[2:0] + 3'h1, r[12:0]}, 1'b0, 1'b0);
      end
      for (int v = 0; v < 4; v++) begin
         r = $urandom;
         acc({2'h1, r[13:0]}, 1'b0, 1'b1);
         acc(vecs[v] + 16'h0001, 1'b1, 1'b0);
         acc(vecs[v], 1'b1, 1'b0);
      end
      repeat (40) begin
         r = $urandom;
         if (r[20])
            @(posedge clk_sys_in) jb <= r[23:21];
         acc(r[15:0], r[16], r[17] & !r[16]);
      end
      for (int i = 0; i < 16; i++) begin
         @(posedge clk_sys_in) btn <= i[3:0];
         repeat (4) @(negedge clk_sys_in);
         chk("buttons", {2'h0, trst_b, tnmi_b}, {2'h0, btn[3] | btn[1], btn[2] | btn[0]});
      end
      acc(16'h4000, 1'b0, 1'b1);
      @(posedge clk_sys_in) rst_b <= 1'b0;
      repeat (4) @(negedge clk_sys_in);
      usr_m = 1'b0;
      pend = 2'h0;
      chk("reset", {rom_b, ram_b, tgt_b, user}, 4'he);
      @(posedge clk_sys_in) rst_b <= 1'b1;
      acc(16'h0100, 1'b1, 1'b0);
      report_and_stop();
   end
endmodule // emm_mapper_bench
`default_nettype wire
